/* File: logic/ouhbd_axil.sv */
// AXI4-Lite slave front end with a simple register strobe interface.
// Assumes one clock; the parent decodes addresses combinationally.
`timescale 1ns/1ps
module ouhbd_axil (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Register strobes
  output logic             reg_wr,
  output logic [3:0]       reg_waddr,
  output logic [31:0]      reg_wdata,
  output logic [3:0]       reg_wstrb,
  input  wire logic        reg_wr_err,
  output logic             reg_rd,
  output logic [3:0]       reg_raddr,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        reg_rd_err
);
  logic        aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [3:0]  aw_addr_reg, aw_addr_next, w_strb_reg, w_strb_next;
  logic [31:0] w_data_reg, w_data_next, rdata_reg, rdata_next;
  logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic        aw_have, w_have;

  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign aw_have   = aw_held_reg | (s_axi_awvalid & s_axi_awready);
  assign w_have    = w_held_reg | (s_axi_wvalid & s_axi_wready);
  assign reg_wr    = aw_have & w_have & ~bvalid_reg;
  assign reg_waddr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
  assign reg_wdata = w_held_reg ? w_data_reg : s_axi_wdata;
  assign reg_wstrb = w_held_reg ? w_strb_reg : s_axi_wstrb;
  assign reg_rd    = s_axi_arvalid & s_axi_arready;
  assign reg_raddr = s_axi_araddr;

  always_comb begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next  = w_held_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg & ~s_axi_bready;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg & ~s_axi_rready;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    if (reg_wr) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = reg_wr_err ? ouhbd_pkg::RESP_SLVERR
                                : ouhbd_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_next = 1'b1;
        aw_addr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_next = 1'b1;
        w_data_next = s_axi_wdata;
        w_strb_next = s_axi_wstrb;
      end
    end
    if (reg_rd) begin
      rvalid_next = 1'b1;
      rdata_next  = reg_rdata;
      rresp_next  = reg_rd_err ? ouhbd_pkg::RESP_SLVERR
                               : ouhbd_pkg::RESP_OKAY;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= 2'h0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= 2'h0;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg  <= w_held_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
    end
  end
endmodule : ouhbd_axil

/* File: logic/ouhbd_optregs.sv */
// Option registers: interrupt mask and interrupt poll.
// Assumes the parent issues a one-cycle write strobe per host write.
`timescale 1ns/1ps
module ouhbd_optregs (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Access from the host port
  input  wire logic       opt_wr,
  input  wire logic [5:0] opt_addr,
  input  wire logic [7:0] opt_wdata,
  output logic [7:0]      opt_rdata,
  // Interrupt state
  input  wire logic [7:0] irq_now,
  output logic [7:0]      irq_mask
);
  logic [7:0] irq_mask_reg, irq_mask_next;

  assign irq_mask = irq_mask_reg;

  always_comb begin
    irq_mask_next = irq_mask_reg;
    if (opt_wr && opt_addr == ouhbd_pkg::OPT_MASK_OFS) begin
      irq_mask_next = opt_wdata;
    end
    case (opt_addr)
      ouhbd_pkg::OPT_MASK_OFS: opt_rdata = irq_mask_reg;
      ouhbd_pkg::OPT_POLL_OFS: opt_rdata = irq_now;
      default:                 opt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_reg <= ouhbd_pkg::OPT_MASK_RESET;
    end else begin
      irq_mask_reg <= irq_mask_next;
    end
  end
endmodule : ouhbd_optregs

/* File: logic/ouhbd_pkg.sv */
// Constants shared by the octal UART host bus decoder files.
// Assumes a single 25 MHz clock and synchronous host pin inputs.
package ouhbd_pkg;
  // ---------------------------------------------------------------
  // Host address fields
  // ---------------------------------------------------------------
  localparam int unsigned PANEL_MSB = 7;
  localparam int unsigned PANEL_LSB = 6;
  localparam int unsigned CHAN_MSB  = 5;
  localparam int unsigned CHAN_LSB  = 3;
  localparam int unsigned CHANNELS  = 8;
  localparam logic        MODE_EXPANSION = 1'b1;
  // ---------------------------------------------------------------
  // Option registers, indexed by host address bits 5 to 0
  // ---------------------------------------------------------------
  localparam logic [5:0] OPT_MASK_OFS   = 6'h04;
  localparam logic [5:0] OPT_POLL_OFS   = 6'h05;
  localparam logic [7:0] OPT_MASK_RESET = 8'h00;
  // ---------------------------------------------------------------
  // Channel register bits used by the interrupt merge
  // ---------------------------------------------------------------
  localparam int unsigned MODEM_IRQ_EN_BIT = 3;
  localparam int unsigned FEAT_BLOCK_BIT   = 4;
  localparam int unsigned FEAT_POL_BIT     = 5;
  // ---------------------------------------------------------------
  // AXI4-Lite register map
  // ---------------------------------------------------------------
  localparam logic [3:0]  AXI_CTRL_OFS     = 4'h0;
  localparam logic [3:0]  AXI_STAT_OFS     = 4'h4;
  localparam logic [3:0]  AXI_IRQ_STAT_OFS = 4'h8;
  localparam logic [3:0]  AXI_IRQ_MASK_OFS = 4'hc;
  localparam int unsigned CTRL_EN_BIT      = 0;
  localparam int unsigned CTRL_PANEL_LSB   = 1;
  localparam logic [2:0]  CTRL_RESET       = 3'h1;
  localparam logic [2:0]  IRQ_MASK_RESET   = 3'h0;
  localparam int unsigned EV_WRITE         = 0;
  localparam int unsigned EV_READ          = 1;
  localparam int unsigned EV_GIRQ          = 2;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
endpackage : ouhbd_pkg

/* File: logic/ouhbd_top.sv */
// Host parallel bus decoder and interrupt merge for an octal UART.
// Assumes host pins are synchronous to clock and the host never
// asserts both strobes together; channel logic lies outside.
//
// Functional notes
// - With the mode input low only address bits 5..0 are decoded.
// - Address bits 5..3 pick one of eight channels, bits 2..0 a register.
// - With the mode input high bits 7..6 must match the panel number.
// - The data bus is driven only while read data is returned.
// - A low read strobe puts the addressed register on the data bus.
// - A low write strobe stores the host data in the addressed register.
// - Channel transfers happen only while the channel select is low.
// - In expansion mode only the auxiliary select reaches option registers.
// - In expansion mode the direction output is low while driving data.
// - All eight channel interrupts merge into one global output.
// - A channel joins the merge only with modem bit 3 set and feature bit 4 clear.
// - The poll register shows the eight channel interrupts.
// - The mask register blocks single channels from the global output.
`timescale 1ns/1ps
module ouhbd_top (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Host parallel port
  input  wire logic [7:0]  host_address_bit,
  input  wire logic [7:0]  host_data_in,
  output logic [7:0]       host_data_out,
  output logic             host_data_oe,
  input  wire logic        read_strobe_n,
  input  wire logic        write_strobe_n,
  input  wire logic        channel_select_n,
  input  wire logic        aux_reg_select_n,
  input  wire logic        multiport_expansion_mode,
  output logic             transceiver_dir_n,
  output logic             global_irq,
  // Channel register side
  output logic [7:0]       ch_wr_pulse,
  output logic [7:0]       ch_rd_pulse,
  output logic [2:0]       ch_reg_addr,
  output logic [7:0]       ch_wdata,
  input  wire logic [63:0] ch_rdata,
  input  wire logic [7:0]  channel_irq,
  input  wire logic [63:0] modem_ctl_reg,
  input  wire logic [63:0] extra_feature_reg,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Software interrupt
  output logic             axi_irq
);
  // Returns a one-hot channel strobe for a channel number.
  function automatic logic [7:0] chan_hot(input logic [2:0] ch);
    chan_hot = 8'h01 << ch;
  endfunction : chan_hot

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic [2:0] ctrl_reg, ctrl_next;
  logic       port_en, panel_hit, chan_sel, opt_sel, any_sel;
  logic [2:0] chan_num;
  logic [7:0] chan_byte, opt_rdata, irq_mask;

  assign port_en  = ctrl_reg[ouhbd_pkg::CTRL_EN_BIT];
  assign chan_num = host_address_bit[ouhbd_pkg::CHAN_MSB:
                                     ouhbd_pkg::CHAN_LSB];
  assign panel_hit = (multiport_expansion_mode !=
                      ouhbd_pkg::MODE_EXPANSION) ||
    (host_address_bit[ouhbd_pkg::PANEL_MSB:ouhbd_pkg::PANEL_LSB] ==
     ctrl_reg[ouhbd_pkg::CTRL_PANEL_LSB +: 2]);
  assign opt_sel = port_en && panel_hit && !aux_reg_select_n &&
    multiport_expansion_mode == ouhbd_pkg::MODE_EXPANSION;
  assign chan_sel = port_en && panel_hit && !channel_select_n &&
    !opt_sel;
  assign any_sel   = chan_sel | opt_sel;
  assign chan_byte = ch_rdata[chan_num*8 +: 8];

  // ---------------------------------------------------------------
  // Strobe handling and data bus
  // ---------------------------------------------------------------
  logic       wr_low_reg, rd_low_reg, wr_first, rd_first, rd_act;
  logic [7:0] data_out_reg, data_out_next, wdata_reg, wdata_next;
  logic [7:0] wr_pulse_reg, wr_pulse_next, rd_pulse_reg, rd_pulse_next;
  logic [2:0] reg_addr_reg, reg_addr_next;
  logic       oe_reg, oe_next, opt_wr;
  logic [7:0] last_addr_reg, last_addr_next;

  assign rd_act   = !read_strobe_n && any_sel;
  assign wr_first = !write_strobe_n && !wr_low_reg && any_sel;
  assign rd_first = rd_act && !rd_low_reg;
  assign opt_wr   = wr_first && opt_sel;

  always_comb begin
    data_out_next  = data_out_reg;
    oe_next        = rd_act;
    wr_pulse_next  = 8'h00;
    rd_pulse_next  = 8'h00;
    wdata_next     = wdata_reg;
    reg_addr_next  = reg_addr_reg;
    last_addr_next = last_addr_reg;
    if (rd_act) begin
      data_out_next = opt_sel ? opt_rdata : chan_byte;
    end
    if (rd_first && chan_sel) begin
      rd_pulse_next = chan_hot(chan_num);
      reg_addr_next = host_address_bit[2:0];
    end
    if (wr_first && chan_sel) begin
      wr_pulse_next = chan_hot(chan_num);
      reg_addr_next = host_address_bit[2:0];
      wdata_next    = host_data_in;
    end
    if (wr_first || rd_first) begin
      last_addr_next = host_address_bit;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_low_reg    <= 1'b0;
      rd_low_reg    <= 1'b0;
      data_out_reg  <= 8'h00;
      oe_reg        <= 1'b0;
      wr_pulse_reg  <= 8'h00;
      rd_pulse_reg  <= 8'h00;
      wdata_reg     <= 8'h00;
      reg_addr_reg  <= 3'h0;
      last_addr_reg <= 8'h00;
    end else begin
      wr_low_reg    <= !write_strobe_n;
      rd_low_reg    <= rd_act;
      data_out_reg  <= data_out_next;
      oe_reg        <= oe_next;
      wr_pulse_reg  <= wr_pulse_next;
      rd_pulse_reg  <= rd_pulse_next;
      wdata_reg     <= wdata_next;
      reg_addr_reg  <= reg_addr_next;
      last_addr_reg <= last_addr_next;
    end
  end

  assign host_data_out = data_out_reg;
  assign host_data_oe  = oe_reg;
  assign ch_wr_pulse   = wr_pulse_reg;
  assign ch_rd_pulse   = rd_pulse_reg;
  assign ch_wdata      = wdata_reg;
  assign ch_reg_addr   = reg_addr_reg;

  // ---------------------------------------------------------------
  // Transceiver direction and global interrupt
  // ---------------------------------------------------------------
  logic       dir_n_reg, dir_n_next, girq_reg, girq_next;
  logic       raw_reg, raw_next, irq_pol;
  logic [7:0] irq_gated;

  assign irq_pol = extra_feature_reg[ouhbd_pkg::FEAT_POL_BIT];

  always_comb begin
    for (int i = 0; i < ouhbd_pkg::CHANNELS; i++) begin
      irq_gated[i] = channel_irq[i] && !irq_mask[i] &&
        modem_ctl_reg[i*8 + ouhbd_pkg::MODEM_IRQ_EN_BIT] &&
        !extra_feature_reg[i*8 + ouhbd_pkg::FEAT_BLOCK_BIT];
    end
    raw_next   = |irq_gated;
    girq_next  = irq_pol ? raw_next : !raw_next;
    dir_n_next = !(rd_act && multiport_expansion_mode ==
                   ouhbd_pkg::MODE_EXPANSION);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dir_n_reg <= 1'b1;
      girq_reg  <= 1'b0;
      raw_reg   <= 1'b0;
    end else begin
      dir_n_reg <= dir_n_next;
      girq_reg  <= girq_next;
      raw_reg   <= raw_next;
    end
  end

  assign transceiver_dir_n = dir_n_reg;
  assign global_irq        = girq_reg;

  ouhbd_optregs ouhbd_optregs_i (
    .clock     (clock),
    .rst_n     (rst_n),
    .opt_wr    (opt_wr),
    .opt_addr  (host_address_bit[5:0]),
    .opt_wdata (host_data_in),
    .opt_rdata (opt_rdata),
    .irq_now   (channel_irq),
    .irq_mask  (irq_mask)
  );

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  logic        reg_wr, reg_rd, wr_err, rd_err;
  logic [3:0]  reg_waddr, reg_raddr, reg_wstrb;
  logic [31:0] reg_wdata, reg_rdata;
  logic [2:0]  stat_reg, stat_next, mask_reg, mask_next, events;

  assign events = {raw_next & ~raw_reg, rd_first, wr_first};

  always_comb begin
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    wr_err    = 1'b0;
    rd_err    = 1'b0;
    reg_rdata = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_waddr)
        ouhbd_pkg::AXI_CTRL_OFS:
          if (reg_wstrb[0]) ctrl_next = reg_wdata[2:0];
        ouhbd_pkg::AXI_IRQ_MASK_OFS:
          if (reg_wstrb[0]) mask_next = reg_wdata[2:0];
        ouhbd_pkg::AXI_STAT_OFS, ouhbd_pkg::AXI_IRQ_STAT_OFS: ;
        default: wr_err = 1'b1;
      endcase
    end
    case (reg_raddr)
      ouhbd_pkg::AXI_CTRL_OFS:     reg_rdata = {29'h0, ctrl_reg};
      ouhbd_pkg::AXI_STAT_OFS:
        reg_rdata = {8'h00, channel_irq, last_addr_reg, 4'h0,
                     multiport_expansion_mode, raw_reg, oe_reg,
                     port_en};
      ouhbd_pkg::AXI_IRQ_STAT_OFS: reg_rdata = {29'h0, stat_reg};
      ouhbd_pkg::AXI_IRQ_MASK_OFS: reg_rdata = {29'h0, mask_reg};
      default:                     rd_err = 1'b1;
    endcase
    if (reg_rd && reg_raddr == ouhbd_pkg::AXI_IRQ_STAT_OFS) begin
      stat_next = 3'h0;
    end
    stat_next = stat_next | events;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= ouhbd_pkg::CTRL_RESET;
      mask_reg <= ouhbd_pkg::IRQ_MASK_RESET;
      stat_reg <= 3'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
      stat_reg <= stat_next;
    end
  end

  assign axi_irq = |(stat_reg & mask_reg);

  ouhbd_axil ouhbd_axil_i (
    .clock         (clock),
    .rst_n         (rst_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .reg_wr        (reg_wr),
    .reg_waddr     (reg_waddr),
    .reg_wdata     (reg_wdata),
    .reg_wstrb     (reg_wstrb),
    .reg_wr_err    (wr_err),
    .reg_rd        (reg_rd),
    .reg_raddr     (reg_raddr),
    .reg_rdata     (reg_rdata),
    .reg_rd_err    (rd_err)
  );

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence host_write_start;
    !write_strobe_n && !wr_low_reg && port_en && !channel_select_n &&
    aux_reg_select_n;
  endsequence

  normal_upper_ignored_a: assert property (
    host_write_start and !multiport_expansion_mode |=> ch_wr_pulse != 8'h00)
    else $error("normal mode write not decoded");
  channel_strobe_a: assert property (
    host_write_start |=> (ch_wr_pulse == 8'h00 ||
      ch_wr_pulse == chan_hot($past(chan_num))))
    else $error("wrong channel strobed");
  panel_mismatch_a: assert property (
    host_write_start and multiport_expansion_mode and !panel_hit
    |=> ch_wr_pulse == 8'h00)
    else $error("foreign panel address accepted");
  bus_drive_a: assert property (
    host_data_oe |-> !$past(read_strobe_n))
    else $error("data bus driven without read strobe");
  read_data_a: assert property (
    !read_strobe_n && chan_sel |=> host_data_out == $past(chan_byte)
    && host_data_oe)
    else $error("read data wrong");
  write_data_a: assert property (
    ch_wr_pulse != 8'h00 |-> ch_wdata == $past(host_data_in))
    else $error("write data wrong");
  deselect_quiet_a: assert property (
    channel_select_n && aux_reg_select_n
    |=> ch_wr_pulse == 8'h00 && !host_data_oe)
    else $error("transfer without select");
  aux_normal_a: assert property (
    !multiport_expansion_mode && channel_select_n
    |=> ch_wr_pulse == 8'h00 && !host_data_oe)
    else $error("aux select acted in normal mode");
  dir_follow_a: assert property (
    transceiver_dir_n == !(host_data_oe && $past(multiport_expansion_mode)))
    else $error("direction output wrong");
  irq_idle_level_a: assert property (
    irq_gated == 8'h00 |=> global_irq == !$past(irq_pol))
    else $error("global interrupt active with no source");
  poll_read_a: assert property (
    !read_strobe_n && opt_sel &&
    host_address_bit[5:0] == ouhbd_pkg::OPT_POLL_OFS
    |=> host_data_out == $past(channel_irq))
    else $error("poll register wrong");
endmodule : ouhbd_top

/* File: tb/octal_uart_host_bus_decode_test.sv */
// Self-checking bench for the host bus decoder and interrupt merge.
// Assumes the channel model answers reads for the live address.
`timescale 1ns/1ps
module octal_uart_host_bus_decode_test;
  logic clock = 0, rst_n = 0, ha, hw, hb;
  logic [7:0] host_address_bit = 0, host_data_in = 0, channel_irq = 8'h81;
  logic read_strobe_n = 1, write_strobe_n = 1, channel_select_n = 1;
  logic aux_reg_select_n = 1, multiport_expansion_mode = 0;
  logic [63:0] modem_ctl_reg = {8{8'h08}}, extra_feature_reg = 0, ch_rdata;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, axi_irq, global_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [7:0] host_data_out, ch_wr_pulse, ch_wdata, ch_rd_pulse;
  logic [2:0] ch_reg_addr;
  logic host_data_oe, transceiver_dir_n;
  int num_errors = 0, total_checks = 0;
  ouhbd_top ouhbd_top_i (.clock, .rst_n, .host_address_bit, .host_data_in,
    .host_data_out, .host_data_oe, .read_strobe_n, .write_strobe_n,
    .channel_select_n, .aux_reg_select_n, .multiport_expansion_mode,
    .transceiver_dir_n, .global_irq, .ch_wr_pulse, .ch_rd_pulse,
    .ch_reg_addr, .ch_wdata, .ch_rdata, .channel_irq, .modem_ctl_reg,
    .extra_feature_reg, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .axi_irq);
  ouhbd_chan_model ouhbd_chan_model_i (.clock, .ch_wr_pulse, .ch_reg_addr,
    .ch_wdata, .live_addr(host_address_bit[2:0]), .ch_rdata);
  always #20 clock = ~clock;
  task chk(input logic [31:0] g, e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task hwr(input logic [7:0] a, d, input logic c, o);
    @(posedge clock);
    host_address_bit <= a;
    host_data_in <= d;
    channel_select_n <= c;
    aux_reg_select_n <= o;
    write_strobe_n <= 0;
    repeat (2) @(posedge clock);
    write_strobe_n <= 1;
    channel_select_n <= 1;
    aux_reg_select_n <= 1;
  endtask : hwr
  task hrd(input logic [7:0] a, e, input logic c, o, v, n);
    @(posedge clock);
    host_address_bit <= a;
    channel_select_n <= c;
    aux_reg_select_n <= o;
    read_strobe_n <= 0;
    @(posedge clock);
    #1 chk(ch_rd_pulse, (v && !c) ? 8'h01 << a[5:3] : 8'h00);
    @(posedge clock);
    #1 chk(host_data_oe, v);
    if (v) chk(host_data_out, e);
    chk(transceiver_dir_n, n);
    @(posedge clock);
    read_strobe_n <= 1;
    channel_select_n <= 1;
    aux_reg_select_n <= 1;
    repeat (2) @(posedge clock);
    #1 chk({host_data_oe, transceiver_dir_n}, 2'h1);
  endtask : hrd
  task irq(input logic [7:0] ci, input logic [63:0] ef, input logic e);
    @(posedge clock);
    channel_irq <= ci;
    extra_feature_reg <= ef;
    repeat (3) @(posedge clock);
    #1 chk(global_irq, e);
  endtask : irq
  task axw(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(negedge clock);
      ha = s_axi_awvalid & s_axi_awready;
      hw = s_axi_wvalid & s_axi_wready;
      hb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge clock);
      if (ha) s_axi_awvalid <= 0;
      if (hw) s_axi_wvalid <= 0;
    end while (!hb);
    s_axi_bready <= 0;
  endtask : axw
  task axr(input logic [3:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(negedge clock);
      ha = s_axi_arvalid & s_axi_arready;
      hb = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clock);
      if (ha) s_axi_arvalid <= 0;
    end while (!hb);
    s_axi_rready <= 0;
  endtask : axr
  task stop_test;
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  initial begin
    #400000;
    num_errors++;
    stop_test;
  end
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1;
    axr(4'h0);
    chk(rd, 32'h1);
    axr(4'hc);
    chk(rd, 32'h0);
    axr(4'h2);
    chk(rs, 2'h2);
    axw(4'h2, 32'h0);
    chk(rs, 2'h2);
    hwr(8'hea, 8'ha5, 0, 1);
    hrd(8'h2a, 8'ha5, 0, 1, 1, 1);
    hrd(8'h22, 8'h00, 0, 1, 1, 1);
    hwr(8'h2a, 8'h11, 1, 1);
    hrd(8'h2a, 8'ha5, 0, 1, 1, 1);
    multiport_expansion_mode <= 1;
    axw(4'h0, 32'h5);
    chk(rs, 2'h0);
    hwr(8'h9a, 8'h3c, 0, 1);
    hwr(8'h5a, 8'hff, 0, 1);
    hrd(8'h9a, 8'h3c, 0, 1, 1, 0);
    hrd(8'h5a, 8'h00, 0, 1, 0, 1);
    hwr(8'h84, 8'h04, 1, 0);
    hrd(8'h84, 8'h04, 1, 0, 1, 0);
    hrd(8'h85, 8'h81, 1, 0, 1, 0);
    axr(4'h4);
    chk(rd, 32'h0081_850d);
    irq(8'h81, 64'h0, 0);
    irq(8'h04, 64'h0, 1);
    irq(8'h04, 64'h20, 0);
    hwr(8'h84, 8'h00, 1, 0);
    irq(8'h04, 64'h20, 1);
    irq(8'h04, 64'h10_0020, 0);
    modem_ctl_reg <= 0;
    irq(8'h04, 64'h20, 0);
    axw(4'hc, 32'h3);
    #1 chk(axi_irq, 1);
    axr(4'h8);
    chk(rd[1:0], 2'h3);
    #1 chk(axi_irq, 0);
    stop_test;
  end
endmodule : octal_uart_host_bus_decode_test

/* File: tb/ouhbd_chan_model.sv */
// Behavioural model of the eight channel register banks.
// Assumes one-hot write pulses and a live host register index.
`timescale 1ns/1ps
module ouhbd_chan_model (
  // Clock
  input  wire logic        clock,
  // Channel register side
  input  wire logic [7:0]  ch_wr_pulse,
  input  wire logic [2:0]  ch_reg_addr,
  input  wire logic [7:0]  ch_wdata,
  input  wire logic [2:0]  live_addr,
  output logic [63:0]      ch_rdata
);
  logic [7:0] mem [64] = '{default: 8'h00};
  always @(posedge clock) begin
    for (int n = 0; n < 8; n++) begin
      if (ch_wr_pulse[n]) mem[{n[2:0], ch_reg_addr}] <= ch_wdata;
    end
  end
  always_comb begin
    for (int n = 0; n < 8; n++) ch_rdata[8*n +: 8] = mem[{n[2:0], live_addr}];
  end
endmodule : ouhbd_chan_model
